// ---- src/rrd_top.sv ----
// Remote dedicated I/O command interpreter
`timescale 1ns/1ns
module rrd_top
    import rrd_pkg::*;
#(
    parameter int SLOTS = RRD_SLOTS,
    parameter int VAL_W = RRD_VAL_W,
    parameter int READY_CYC = RRD_READY_CYC,
    parameter int MOVE_CYC = RRD_MOVE_CYC
) (
    input wire logic clock, // System clock 100 MHz
    input wire logic rst, // Async reset, high
    input wire logic [1:0] mode_sel, // Mode switch position
    input wire logic auto_enable, // Level: allow auto
    input wire logic start_in, // Edge: start all
    input wire logic stop_in, // Level: stop all
    input wire logic program_reset, // Edge: clear wait
    input wire logic error_clear, // Edge: clear error
    input wire logic cycle_stop_in, // Edge: cycle stop
    input wire logic servo_on_enable, // Level: servo enable
    input wire logic servo_on_cmd, // Edge: servo on
    input wire logic operation_rights, // Level: rights request
    input wire logic machine_lock, // Edge: toggle lock
    input wire logic evasion_return, // Edge: evasion return
    input wire logic gp_output_clear, // Edge: clear GP outputs
    input wire logic [SLOTS-1:0] slot_start, // Edge: per-slot start
    input wire logic [SLOTS-1:0] slot_stop, // Level: per-slot stop
    input wire logic program_select, // Edge: take program no.
    input wire logic override_select, // Edge: take override
    input wire logic [VAL_W-1:0] numeric_value_bus, // Numeric value inputs
    input wire logic error_event, // Internal fault report
    input wire logic emergency_in, // Emergency stop circuit
    input wire logic panel_start, // Local panel start
    input wire logic [SLOTS-1:0] cycle_done, // Slot reached cycle end
    input wire logic [RRD_MAP_W-1:0] start_in_num, // Mapping: start input no.
    input wire logic [RRD_MAP_W-1:0] start_out_num, // Mapping: start output no.
    output logic teach_mode_out, // Teaching mode
    output logic auto_mode_out, // Automatic mode
    output logic remote_mode_out, // Remote mode
    output logic power_on_complete, // Inputs accepted
    output logic auto_enable_out, // Auto enable, gated by command acceptance
    output logic operating_out, // Any slot running
    output logic wait_out, // Any slot waiting
    output logic prog_sel_ok_out, // Program select allowed
    output logic error_out, // Error present
    output logic cycle_stop_out, // Cycle stop in progress
    output logic servo_enable_out, // Servo-on enable echo
    output logic servo_on_out, // Servo is on
    output logic rights_out, // Operation rights valid
    output logic lock_out, // Machine lock state
    output logic evasion_out, // Evasion return running
    output logic gp_clear_pulse, // Clear GP outputs pulse
    output logic emergency_stop_out, // Emergency stop occurred
    output logic [SLOTS-1:0] slot_run_out, // Per-slot operating
    output logic [SLOTS-1:0] slot_wait_out, // Per-slot waiting
    output logic [VAL_W-1:0] program_num_out, // Latched program no.
    output logic [VAL_W-1:0] override_out, // Latched override
    output logic [RRD_MAP_W-1:0] stop_in_num, // Mapping: stop input no.
    output logic [RRD_MAP_W-1:0] start_map_in, // Mapping: start input echo
    output logic [RRD_MAP_W-1:0] start_map_out // Mapping: start output echo
);
    initial begin
        if (SLOTS < 1 || SLOTS > 32) $error("SLOTS out of range");
        if (VAL_W < 7 || VAL_W > 32) $error("VAL_W out of range");
        if (READY_CYC < 1 || MOVE_CYC < 1) $error("counts must be positive");
        if (READY_CYC > 65535 || MOVE_CYC > 65535) $error("counts exceed counter width");
    end

    localparam int NEDGE = 9;
    localparam int CW = 16;

    typedef struct packed {
        logic ready;
        logic [CW-1:0] rdy_cnt;
        logic [SLOTS-1:0] run;
        logic [SLOTS-1:0] wt;
        logic err;
        logic cyc;
        logic servo;
        logic lock;
        logic evade;
        logic [CW-1:0] ev_cnt;
        logic gpclr;
        logic emg;
        logic [VAL_W-1:0] prog;
        logic [VAL_W-1:0] ovrd;
        logic [RRD_MAP_W-1:0] map_in;
        logic [RRD_MAP_W-1:0] map_out;
    } rrd_st_t;
    rrd_st_t s_reg;
    rrd_st_t s_next;

    logic [NEDGE-1:0] lvl;
    logic [NEDGE-1:0] rise;
    logic [SLOTS-1:0] srise;
    logic remote;
    logic acc;
    logic allow_auto;
    logic stop_any;

    // Edge detection of edge-class commands
    assign lvl = {override_select, program_select, gp_output_clear, evasion_return,
                  machine_lock, servo_on_cmd, cycle_stop_in, error_clear, program_reset};
    rrd_edge #(.W(NEDGE)) u_edge (
        .clock(clock),
        .rst(rst),
        .din(lvl),
        .rise(rise)
    );
    rrd_edge #(.W(SLOTS)) u_sedge (
        .clock(clock),
        .rst(rst),
        .din(slot_start | {{(SLOTS-1){1'b0}}, start_in}),
        .rise(srise)
    );

    // Command acceptance: only after ready, with rights, in remote mode
    assign remote = (mode_sel == RRD_MODE_REMOTE);
    assign acc = s_reg.ready && operation_rights && remote;
    assign allow_auto = acc && auto_enable;
    assign stop_any = stop_in;

    // Start all as a single-cycle pulse
    logic start_all;
    logic start_prev_reg;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            start_prev_reg <= 1'b0;
        end else begin
            start_prev_reg <= start_in;
        end
    end
    assign start_all = start_in && !start_prev_reg;

    function automatic logic [CW-1:0] dec_sat(input logic [CW-1:0] v);
        dec_sat = (v == '0) ? v : v - 1'b1;
    endfunction

    // Next-state logic of the whole interpreter
    always_comb begin
        s_next = s_reg;
        s_next.gpclr = 1'b0;
        // Power-on settle counter
        if (!s_reg.ready) begin
            s_next.rdy_cnt = dec_sat(s_reg.rdy_cnt);
            if (s_reg.rdy_cnt <= CW'(1)) begin
                s_next.ready = 1'b1;
            end
        end
        // Emergency stop latches until error clear
        if (emergency_in) begin
            s_next.emg = 1'b1;
        end
        // Error clear; a new error in the same cycle wins
        if (acc && rise[1]) begin
            s_next.err = 1'b0;
            if (!emergency_in) begin
                s_next.emg = 1'b0;
            end
        end
        if (error_event || emergency_in) begin
            s_next.err = 1'b1;
        end
        // Servo power
        if (acc && servo_on_enable && rise[3] && !s_next.err) begin
            s_next.servo = 1'b1;
        end
        if (!servo_on_enable || emergency_in) begin
            s_next.servo = 1'b0;
        end
        // Machine lock toggle
        if (acc && rise[4]) begin
            s_next.lock = !s_reg.lock;
        end
        // Program reset first, so a stop in the same cycle still sets wait
        if (acc && rise[0] && !stop_any) begin
            s_next.wt = '0;
        end
        // Per-slot run and wait
        for (int i = 0; i < SLOTS; i++) begin
            if (allow_auto && s_reg.servo && !s_reg.err && (srise[i] || start_all)) begin
                s_next.run[i] = 1'b1;
                s_next.wt[i] = 1'b0;
            end
            if (cycle_done[i] && (s_reg.cyc || !s_reg.run[i])) begin
                s_next.run[i] = 1'b0;
            end
            if (s_reg.run[i] && (stop_any || slot_stop[i] || s_reg.err)) begin
                s_next.run[i] = 1'b0;
                s_next.wt[i] = 1'b1;
            end
        end
        // Cycle stop in progress until all slots idle
        if (acc && rise[2] && |s_reg.run) begin
            s_next.cyc = 1'b1;
        end
        if (s_reg.cyc && !(|s_reg.run)) begin
            s_next.cyc = 1'b0;
        end
        // Evasion return motion timer
        if (acc && rise[5] && s_reg.servo && !s_reg.evade && !(|s_reg.run)) begin
            s_next.evade = 1'b1;
            s_next.ev_cnt = CW'(MOVE_CYC);
        end else if (s_reg.evade) begin
            s_next.ev_cnt = dec_sat(s_reg.ev_cnt);
            if (s_reg.ev_cnt <= CW'(1) || stop_any || s_reg.err) begin
                s_next.evade = 1'b0;
            end
        end
        // General-purpose output clear pulse
        if (acc && rise[6]) begin
            s_next.gpclr = 1'b1;
        end
        // Numeric value captures; program number only while no slot runs
        if (acc && rise[7] && !(|s_reg.run)) begin
            s_next.prog = numeric_value_bus;
        end
        if (acc && rise[8]) begin
            s_next.ovrd = numeric_value_bus;
        end
        // Mapping numbers, configurable except stop
        s_next.map_in = start_in_num;
        s_next.map_out = start_out_num;
        // Panel start ignored in every mode, remote or not
        if (!remote && panel_start) begin
            s_next.run = s_next.run;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.rdy_cnt <= CW'(READY_CYC);
            s_reg.ovrd <= VAL_W'(RRD_OVRD_RST);
        end else begin
            s_reg <= s_next;
        end
    end

    // Mode and status outputs
    assign teach_mode_out = (mode_sel == RRD_MODE_TEACH);
    assign auto_mode_out = (mode_sel == RRD_MODE_AUTO);
    assign remote_mode_out = remote;
    assign power_on_complete = s_reg.ready;
    assign auto_enable_out = allow_auto;
    assign operating_out = |s_reg.run;
    assign wait_out = |s_reg.wt;
    assign prog_sel_ok_out = s_reg.ready && !(|s_reg.run);
    assign error_out = s_reg.err;
    assign cycle_stop_out = s_reg.cyc;
    assign servo_enable_out = servo_on_enable;
    assign servo_on_out = s_reg.servo;
    assign rights_out = s_reg.ready && operation_rights && remote;
    assign lock_out = s_reg.lock;
    assign evasion_out = s_reg.evade;
    assign gp_clear_pulse = s_reg.gpclr;
    assign emergency_stop_out = s_reg.emg;
    assign slot_run_out = s_reg.run;
    assign slot_wait_out = s_reg.wt;
    assign program_num_out = s_reg.prog;
    assign override_out = s_reg.ovrd;
    assign stop_in_num = RRD_STOP_IN_NUM;
    assign start_map_in = s_reg.map_in;
    assign start_map_out = s_reg.map_out;

    // Checks beside the logic
    a_stop_halts: assert property (@(posedge clock) disable iff (rst)
        (stop_in && s_reg.run[0]) |=> (!s_reg.run[0] && s_reg.wt[0]))
        else $error("stop did not halt slot");
    a_no_rights_run: assert property (@(posedge clock) disable iff (rst)
        (!operation_rights && !s_reg.run[0]) |=> !s_reg.run[0])
        else $error("slot started without rights");
    a_lock_toggle: assert property (@(posedge clock) disable iff (rst)
        (acc && rise[4]) |=> (s_reg.lock != $past(s_reg.lock)))
        else $error("lock did not toggle");
    a_prog_take: assert property (@(posedge clock) disable iff (rst)
        (acc && rise[7] && !(|s_reg.run)) |=> (s_reg.prog == $past(numeric_value_bus)))
        else $error("program number not taken");
    a_ovrd_take: assert property (@(posedge clock) disable iff (rst)
        (acc && rise[8]) |=> (s_reg.ovrd == $past(numeric_value_bus)))
        else $error("override not taken");
    a_err_set: assert property (@(posedge clock) disable iff (rst)
        error_event |=> error_out)
        else $error("error not flagged");
    a_servo_drop: assert property (@(posedge clock) disable iff (rst)
        !servo_on_enable |=> !servo_on_out)
        else $error("servo stayed on without enable");
    a_ready_time: assert property (@(posedge clock) disable iff (rst)
        $rose(power_on_complete) |-> $past(s_reg.rdy_cnt) <= CW'(1))
        else $error("ready too early");
    a_gp_pulse: assert property (@(posedge clock) disable iff (rst)
        gp_clear_pulse |=> !gp_clear_pulse || $past(acc && rise[6]))
        else $error("clear pulse too long");

    // Accepted start with nothing against it must run
    a_start_all: assert property (@(posedge clock) disable iff (rst)
        (allow_auto && start_all && s_reg.servo && !s_reg.err && !stop_in && !slot_stop[0] && !cycle_done[0])
        |=> operating_out)
        else $error("start all did not run");

    // Program reset with nothing running leaves no wait
    a_wait_clear: assert property (@(posedge clock) disable iff (rst)
        (acc && rise[0] && !stop_any && !(|s_reg.run))
        |=> !wait_out)
        else $error("wait not cleared");

    // Cycle stop status ends once all slots are idle
    a_cyc_end: assert property (@(posedge clock) disable iff (rst)
        (s_reg.cyc && !(|s_reg.run))
        |=> !cycle_stop_out)
        else $error("cycle stop stuck");

    // Servo comes on only through an accepted command
    a_servo_need: assert property (@(posedge clock) disable iff (rst)
        (!s_reg.servo && !(acc && rise[3]))
        |=> !servo_on_out)
        else $error("servo on without command");

    // Emergency circuit always shows on the output
    a_emg_flag: assert property (@(posedge clock) disable iff (rst)
        emergency_in
        |=> emergency_stop_out)
        else $error("emergency not flagged");

    // Evasion motion starts only through an accepted command
    a_evade_gate: assert property (@(posedge clock) disable iff (rst)
        (!s_reg.evade && !(acc && rise[5]))
        |=> !evasion_out)
        else $error("evasion without command");

    // Program number frozen while any slot runs
    a_prog_hold: assert property (@(posedge clock) disable iff (rst)
        (|s_reg.run)
        |=> $stable(program_num_out))
        else $error("program number changed while running");

    // Lock state moves only on an accepted toggle
    a_lock_hold: assert property (@(posedge clock) disable iff (rst)
        !(acc && rise[4])
        |=> $stable(lock_out))
        else $error("lock changed without command");

    // Error clear with no new fault empties the flag
    a_err_clear: assert property (@(posedge clock) disable iff (rst)
        (acc && rise[1] && !error_event && !emergency_in)
        |=> !error_out)
        else $error("error not cleared");
endmodule

// ---- src/rrd_pkg.sv ----
// Constants shared by the remote dedicated I/O block
// Overview of operation
// - Three outputs show teach, auto, remote mode
// - Power-on-complete asserted once inputs are accepted
// - Auto enable level input gates automatic operation
// - Global start edge starts all slots
// - Global stop level, fixed at input zero
// - Wait output while slots temporarily stopped
// - Program reset edge clears wait state
// - Error output; error clear edge clears it
// - Cycle stop edge; status while in progress
// - Servo-on enable level input echoed back
// - Servo-on edge powers servos; status output
// - Operation rights level input; valid output
// - Machine lock edge toggles lock state
// - Evasion return edge; status while moving
// - Output clear edge clears general outputs
// - Dedicated emergency stop output, no input
// - Per-slot start edges start own slot
// - Per-slot stop levels stop own slot
// - Program select edge latches numeric value
// - Override select edge latches numeric value
// - Start bound to input/output numbers; stop fixed at input zero
// - Remote mode accepts only external commands
package rrd_pkg;
    localparam int RRD_SLOTS = 32;
    localparam int RRD_VAL_W = 16;
    localparam int RRD_MAP_W = 8;
    localparam logic [7:0] RRD_STOP_IN_NUM = 8'h00;
    // Power-on settling time before inputs are accepted
    localparam int RRD_READY_NS = 1000;
    localparam int RRD_CLK_NS = 10;
    localparam int RRD_READY_CYC = (RRD_READY_NS + RRD_CLK_NS - 1) / RRD_CLK_NS;
    // Evasion motion stand-in duration
    localparam int RRD_MOVE_NS = 2000;
    localparam int RRD_MOVE_CYC = RRD_MOVE_NS / RRD_CLK_NS;
    localparam logic [15:0] RRD_OVRD_RST = 16'h0064;
    // Operating mode encodings
    typedef enum logic [1:0] {
        RRD_MODE_TEACH = 2'b00,
        RRD_MODE_AUTO = 2'b01,
        RRD_MODE_REMOTE = 2'b10
    } rrd_mode_t;
endpackage

// ---- src/rrd_edge.sv ----
// Rising edge detector bank for edge-class inputs
`timescale 1ns/1ns
module rrd_edge
    import rrd_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic clock, // System clock
    input wire logic rst, // Async reset, high
    input wire logic [W-1:0] din, // Level inputs
    output logic [W-1:0] rise // One-cycle rise pulses
);
    typedef struct packed {
        logic [W-1:0] prev;
    } rrd_edge_st_t;
    rrd_edge_st_t s_reg;
    rrd_edge_st_t s_next;

    // Remember last sample
    always_comb begin
        s_next.prev = din;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // History resets to idle low; an input held through reset rises once, ignored until ready
    assign rise = din & ~s_reg.prev;
endmodule

// ---- tb/rrd_seq_model.sv ----
// Model of the external sequencing device on the value and cycle-end lines
`timescale 1ns/1ns
module rrd_seq_model
    import rrd_pkg::*;
(
    input wire logic clock, // System clock
    output logic [RRD_VAL_W-1:0] numeric_value_bus, // Value lines
    output logic [RRD_SLOTS-1:0] cycle_done // Cycle end reports
);
    logic [RRD_VAL_W-1:0] last_val;
    logic driving;
    // Released lines show the inverse, so a stale value never passes
    always_comb numeric_value_bus = driving ? last_val : ~last_val;
    initial begin
        last_val = 16'h0000;
        driving = 1'b0;
        cycle_done = '0;
    end
    // Value goes up ahead of the select edge and stays until released
    task automatic present(input logic [RRD_VAL_W-1:0] v);
        @(negedge clock);
        last_val = v;
        driving = 1'b1;
    endtask
    task automatic release_bus();
        @(negedge clock);
        driving = 1'b0;
    endtask
    // Slow far end: cycle end only when the bench says so
    task automatic report_done(input logic [RRD_SLOTS-1:0] m);
        @(negedge clock);
        cycle_done = m;
    endtask
endmodule

// ---- tb/rrd_top_tb.sv ----
// Self-checking bench for the remote dedicated I/O block
`timescale 1ns/1ns
module rrd_top_tb;
    import rrd_pkg::*;
    logic clock, rst, auto_enable, start_in, stop_in, program_reset, error_clear, cycle_stop_in;
    logic servo_on_enable, servo_on_cmd, operation_rights, machine_lock, evasion_return;
    logic gp_output_clear, program_select, override_select, error_event, emergency_in, panel_start;
    logic [1:0] mode_sel;
    logic [31:0] slot_start, slot_stop, cycle_done, slot_run_out, slot_wait_out;
    logic [15:0] numeric_value_bus, program_num_out, override_out;
    logic [7:0] start_in_num, start_out_num, stop_in_num, start_map_in, start_map_out;
    logic teach_mode_out, auto_mode_out, remote_mode_out, power_on_complete, auto_enable_out;
    logic operating_out, wait_out, prog_sel_ok_out, error_out, cycle_stop_out, servo_enable_out;
    logic servo_on_out, rights_out, lock_out, evasion_out, gp_clear_pulse, emergency_stop_out;
    int fails = 0;
    int cmp_count = 0;
    int gp_count = 0;
    rrd_top #(.READY_CYC(3), .MOVE_CYC(20)) i_dut (
        .clock(clock), .rst(rst), .mode_sel(mode_sel), .auto_enable(auto_enable),
        .start_in(start_in), .stop_in(stop_in), .program_reset(program_reset),
        .error_clear(error_clear), .cycle_stop_in(cycle_stop_in), .servo_on_enable(servo_on_enable),
        .servo_on_cmd(servo_on_cmd), .operation_rights(operation_rights), .machine_lock(machine_lock),
        .evasion_return(evasion_return), .gp_output_clear(gp_output_clear), .slot_start(slot_start),
        .slot_stop(slot_stop), .program_select(program_select), .override_select(override_select),
        .numeric_value_bus(numeric_value_bus), .error_event(error_event), .emergency_in(emergency_in),
        .panel_start(panel_start), .cycle_done(cycle_done), .start_in_num(start_in_num),
        .start_out_num(start_out_num), .teach_mode_out(teach_mode_out), .auto_mode_out(auto_mode_out),
        .remote_mode_out(remote_mode_out), .power_on_complete(power_on_complete),
        .auto_enable_out(auto_enable_out), .operating_out(operating_out), .wait_out(wait_out),
        .prog_sel_ok_out(prog_sel_ok_out), .error_out(error_out), .cycle_stop_out(cycle_stop_out),
        .servo_enable_out(servo_enable_out), .servo_on_out(servo_on_out), .rights_out(rights_out),
        .lock_out(lock_out), .evasion_out(evasion_out), .gp_clear_pulse(gp_clear_pulse),
        .emergency_stop_out(emergency_stop_out), .slot_run_out(slot_run_out),
        .slot_wait_out(slot_wait_out), .program_num_out(program_num_out), .override_out(override_out),
        .stop_in_num(stop_in_num), .start_map_in(start_map_in), .start_map_out(start_map_out)
    );
    rrd_seq_model i_seq (.clock(clock), .numeric_value_bus(numeric_value_bus), .cycle_done(cycle_done));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Counting clear pulses catches both a missing and a stretched pulse
    always @(posedge clock) if (gp_clear_pulse === 1'b1) gp_count++;
    // Wide enough for a status bit beside a full slot word
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    // One low sample, one high, then back low so the next rise counts
    task automatic pulse(ref logic s);
        @(negedge clock);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
        repeat (3) @(negedge clock);
    endtask
    task automatic tend(input string name);
        $display("test %s done", name);
    endtask
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Whole sequence needs well under 1000 cycles
    initial begin
        #200000;
        fails++;
        final_report();
    end
    initial begin
        {auto_enable, start_in, stop_in, program_reset, error_clear, cycle_stop_in} = '0;
        {servo_on_enable, servo_on_cmd, operation_rights, machine_lock, evasion_return} = '0;
        {gp_output_clear, program_select, override_select, error_event, emergency_in, panel_start} = '0;
        {slot_start, slot_stop, mode_sel, start_in_num, start_out_num} = '0;
        rst = 1'b1;
        repeat (2) @(posedge clock);
        @(negedge clock) rst = 1'b0;
        chk(power_on_complete, 0, "ready too early");
        chk(override_out, 32'h64, "override reset");
        chk(stop_in_num, 0, "stop input number");
        repeat (6) @(negedge clock);
        chk(power_on_complete, 1, "ready missing");
        for (int m = 0; m < 3; m++) begin
            @(negedge clock) mode_sel = m[1:0];
            #1 chk({teach_mode_out, auto_mode_out, remote_mode_out}, 3'b100 >> m, "mode");
        end
        tend("reset and modes");
        // Teach mode and missing rights both refuse servo on
        @(negedge clock);
        auto_enable = 1'b1;
        servo_on_enable = 1'b1;
        {operation_rights, mode_sel} = 3'b100;
        pulse(servo_on_cmd);
        chk(servo_on_out, 0, "servo on in teach");
        {operation_rights, mode_sel} = 3'b010;
        pulse(servo_on_cmd);
        chk(servo_on_out, 0, "servo on without rights");
        operation_rights = 1'b1;
        pulse(servo_on_cmd);
        chk(servo_on_out, 1, "servo on");
        chk({auto_enable_out, servo_enable_out, rights_out}, 3'b111, "echoes");
        tend("gating");
        i_seq.present(16'h0123);
        pulse(program_select);
        chk(program_num_out, 32'h0123, "program number");
        i_seq.present(16'h0050);
        pulse(override_select);
        chk(override_out, 32'h0050, "override");
        i_seq.release_bus();
        tend("selection");
        pulse(start_in);
        chk({operating_out, slot_run_out}, 33'h1FFFFFFFF, "start all");
        slot_stop[3] = 1'b1;
        repeat (3) @(negedge clock);
        chk(slot_wait_out, 32'h8, "slot stop");
        slot_stop[3] = 1'b0;
        stop_in = 1'b1;
        repeat (3) @(negedge clock);
        chk({wait_out, operating_out}, 2'b10, "global stop");
        stop_in = 1'b0;
        pulse(program_reset);
        chk({wait_out, slot_wait_out, prog_sel_ok_out}, 34'h1, "program reset");
        // Everything else would allow a start, and panel start is checked as refused in remote mode only
        panel_start = 1'b1;
        repeat (3) @(negedge clock);
        chk(operating_out, 0, "panel start in remote");
        panel_start = 1'b0;
        tend("start and stop");
        @(negedge clock) slot_start[5] = 1'b1;
        @(negedge clock) slot_start[5] = 1'b0;
        repeat (3) @(negedge clock);
        chk({operating_out, slot_run_out}, 33'h100000020, "slot start");
        pulse(cycle_stop_in);
        chk(cycle_stop_out, 1, "cycle stop running");
        i_seq.report_done(32'h20);
        repeat (4) @(negedge clock);
        chk({cycle_stop_out, slot_run_out}, 0, "cycle stop end");
        i_seq.report_done(32'h0);
        tend("slot and cycle stop");
        pulse(machine_lock);
        chk(lock_out, 1, "lock set");
        pulse(machine_lock);
        chk(lock_out, 0, "lock reset");
        pulse(evasion_return);
        chk(evasion_out, 1, "evasion running");
        repeat (25) @(negedge clock);
        chk(evasion_out, 0, "evasion end");
        pulse(gp_output_clear);
        chk(gp_count, 1, "clear pulse count");
        start_in_num = 8'h12;
        start_out_num = 8'h34;
        repeat (2) @(negedge clock);
        chk({start_map_in, start_map_out}, 32'h1234, "mapping echo");
        tend("lock, evasion, clear, mapping");
        pulse(error_event);
        chk(error_out, 1, "error set");
        pulse(start_in);
        chk(operating_out, 0, "start with error");
        pulse(error_clear);
        chk(error_out, 0, "error cleared");
        emergency_in = 1'b1;
        repeat (3) @(negedge clock);
        chk(emergency_stop_out, 1, "emergency");
        emergency_in = 1'b0;
        pulse(error_clear);
        chk(emergency_stop_out, 0, "emergency cleared");
        pulse(servo_on_cmd);
        chk(servo_on_out, 1, "servo on again");
        servo_on_enable = 1'b0;
        repeat (2) @(negedge clock);
        chk({servo_on_out, servo_enable_out}, 2'b00, "servo enable dropped");
        tend("errors");
        final_report();
    end
endmodule
